// file: rtl/lds_link_diag.sv
`timescale 1ns/1ps
`default_nettype none
module lds_link_diag #(
   parameter int STEP_CYCLES = lds_pkg::LDS_STEP_CYCLES,
   parameter int HOLD_UNIT_CYCLES = lds_pkg::LDS_HOLD_UNIT_CYCLES,
   parameter logic [7:0] SENSITIVITY = lds_pkg::LDS_SENS_DEF
) (
   input wire logic clock, // 25 MHz clock
   input wire logic sys_rst, // Async reset, high
   input wire logic [2:0] reset_cause, // Cause code, stable at release
   input wire logic cmd_valid, // Command strobe
   input wire logic [3:0] cmd_sel, // Register selector
   input wire logic cmd_has_param, // Parameter present
   input wire logic [15:0] cmd_param, // Parameter value
   output logic cmd_ready, // Sequencer idle
   output logic rsp_valid, // Answer strobe
   output logic rsp_error, // Answer is an error
   output logic [15:0] rsp_data, // Answer value
   input wire logic rx_pkt_done, // Final-hop data packet received
   input wire logic [7:0] rx_rssi, // Its RSSI, -dBm magnitude
   input wire logic rx_integrity_err, // Packet failed integrity checks
   input wire logic rx_good_frame, // Error-free frame, valid MAC header
   input wire logic rx_is_mac_ack, // That frame is a MAC ACK
   input wire logic tx_unicast, // MAC unicast sent
   input wire logic ack_timeout, // MAC ACK timeout expired
   output logic tx_ack_request, // Request ACK on unicasts
   output logic [3:0] mac_retry_limit, // Retry limit to MAC
   output logic chan_req, // Channel power measure pulse
   output logic [7:0] chan_index, // Zero-based channel
   input wire logic chan_done, // Measurement ready
   input wire logic [7:0] chan_power, // Measured power, -dBm
   output logic rssi_pwm // RSSI PWM pin
);
   // ==========================================================================
   // Helpers
   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      sat_inc = (v == lds_pkg::LDS_CNT_MAX) ? v : v + 16'h0001;
   endfunction : sat_inc

   // ==========================================================================
   // State
   lds_pkg::lds_state_t state_q;
   logic [7:0] rssi_q;
   logic [15:0] ack_fail_q;
   logic [15:0] rx_fault_q;
   logic [15:0] good_q;
   logic [15:0] unicast_q;
   logic [7:0] hold_q;
   logic [3:0] retry_q;
   logic [2:0] cause_q;
   logic cause_taken_q;
   logic pwm_active_q;
   logic [5:0] duty_q;
   logic [31:0] step_cnt_q;
   logic [5:0] step_idx_q;
   logic [31:0] unit_cnt_q;
   logic [7:0] hold_cnt_q;

   // ==========================================================================
   // Command decode
   wire logic cmd_take = cmd_valid && (state_q == lds_pkg::LDS_ST_IDLE);
   wire logic wr = cmd_take && cmd_has_param;
   wire logic ld_ack = wr && (cmd_sel == lds_pkg::LDS_SEL_ACK_FAIL);
   wire logic ld_fault = wr && (cmd_sel == lds_pkg::LDS_SEL_RX_FAULT);
   wire logic ld_good = wr && (cmd_sel == lds_pkg::LDS_SEL_GOOD);
   wire logic hold_sel = cmd_sel == lds_pkg::LDS_SEL_HOLD;
   wire logic retry_sel = cmd_sel == lds_pkg::LDS_SEL_RETRY;
   wire logic chan_sel = cmd_sel == lds_pkg::LDS_SEL_CHAN;
   wire logic ld_hold = wr && hold_sel && (cmd_param[15:8] == 8'h00);
   wire logic ld_retry = wr && retry_sel && (cmd_param <= lds_pkg::LDS_RETRY_MAX);
   wire logic chan_start = cmd_take && chan_sel && cmd_has_param
      && (cmd_param[15:8] == 8'h00);

   // Any access to unknown selectors, writes to read-only ones, bad parameters, bare channel queries
   wire logic ro_sel = (cmd_sel == lds_pkg::LDS_SEL_RSSI)
      || (cmd_sel == lds_pkg::LDS_SEL_CAUSE) || (cmd_sel == lds_pkg::LDS_SEL_UNICAST);
   wire logic known_sel = cmd_sel <= lds_pkg::LDS_SEL_CHAN;
   wire logic bad_cmd = !known_sel
      || (chan_sel && !chan_start)
      || (wr && ro_sel)
      || (wr && hold_sel && !ld_hold)
      || (wr && retry_sel && !ld_retry);

   // Read mux
   logic [15:0] rd_data;
   always_comb
   begin
      unique case (cmd_sel)
         lds_pkg::LDS_SEL_RSSI: rd_data = {8'h00, rssi_q};
         lds_pkg::LDS_SEL_ACK_FAIL: rd_data = ack_fail_q;
         lds_pkg::LDS_SEL_RX_FAULT: rd_data = rx_fault_q;
         lds_pkg::LDS_SEL_GOOD: rd_data = good_q;
         lds_pkg::LDS_SEL_CAUSE: rd_data = {13'h0000, cause_q};
         lds_pkg::LDS_SEL_UNICAST: rd_data = unicast_q;
         lds_pkg::LDS_SEL_HOLD: rd_data = {8'h00, hold_q};
         lds_pkg::LDS_SEL_RETRY: rd_data = {12'h000, retry_q};
         default: rd_data = 16'h0000;
      endcase
   end

   // ==========================================================================
   // Command sequencer and answers
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q <= lds_pkg::LDS_ST_IDLE;
         rsp_valid <= 1'b0;
         rsp_error <= 1'b0;
         rsp_data <= 16'h0000;
         chan_req <= 1'b0;
         chan_index <= 8'h00;
      end
      else
      begin
         rsp_valid <= 1'b0;
         chan_req <= 1'b0;
         unique case (state_q)
            lds_pkg::LDS_ST_IDLE:
            begin
               if (chan_start)
               begin
                  chan_req <= 1'b1;
                  chan_index <= cmd_param[7:0];
                  state_q <= lds_pkg::LDS_ST_CHAN;
               end
               else if (cmd_take)
               begin
                  rsp_valid <= 1'b1;
                  rsp_error <= bad_cmd;
                  rsp_data <= (bad_cmd || wr) ? 16'h0000 : rd_data;
               end
            end
            lds_pkg::LDS_ST_CHAN:
            begin
               if (chan_done)
               begin
                  rsp_valid <= 1'b1;
                  rsp_error <= 1'b0;
                  rsp_data <= {8'h00, chan_power};
                  state_q <= lds_pkg::LDS_ST_IDLE;
               end
            end
         endcase
      end
   end

   // Ready mirrors idle state, registered
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         cmd_ready <= 1'b0;
      else
         cmd_ready <= (state_q == lds_pkg::LDS_ST_IDLE) && !chan_start;
   end

   // ==========================================================================
   // Statistics counters; host load wins over a same-cycle event
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ack_fail_q <= lds_pkg::LDS_CNT_RST;
         rx_fault_q <= lds_pkg::LDS_CNT_RST;
         good_q <= lds_pkg::LDS_CNT_RST;
         unicast_q <= lds_pkg::LDS_CNT_RST;
      end
      else
      begin
         if (ld_ack)
            ack_fail_q <= cmd_param;
         else if (ack_timeout)
            ack_fail_q <= sat_inc(ack_fail_q);
         if (ld_fault)
            rx_fault_q <= cmd_param;
         else if (rx_integrity_err)
            rx_fault_q <= sat_inc(rx_fault_q);
         if (ld_good)
            good_q <= cmd_param;
         else if (rx_good_frame && !rx_is_mac_ack)
            good_q <= sat_inc(good_q);
         if (tx_unicast && (retry_q != 4'h0))
            unicast_q <= sat_inc(unicast_q);
      end
   end

   // ==========================================================================
   // Configuration registers and ACK request
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hold_q <= lds_pkg::LDS_HOLD_RST;
         retry_q <= lds_pkg::LDS_RETRY_RST;
         tx_ack_request <= 1'b1;
         mac_retry_limit <= lds_pkg::LDS_RETRY_RST;
      end
      else
      begin
         if (ld_hold)
            hold_q <= cmd_param[7:0];
         if (ld_retry)
            retry_q <= cmd_param[3:0];
         tx_ack_request <= (retry_q != 4'h0);
         mac_retry_limit <= retry_q;
      end
   end

   // ==========================================================================
   // Reset cause captured once after release
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cause_q <= lds_pkg::LDS_CAUSE_POWER;
         cause_taken_q <= 1'b0;
      end
      else if (!cause_taken_q)
      begin
         cause_taken_q <= 1'b1;
         unique case (reset_cause)
            lds_pkg::LDS_CAUSE_WDOG, lds_pkg::LDS_CAUSE_SOFT,
            lds_pkg::LDS_CAUSE_LINE, lds_pkg::LDS_CAUSE_BROWN:
               cause_q <= reset_cause;
            default: cause_q <= lds_pkg::LDS_CAUSE_POWER;
         endcase
      end
   end

   // ==========================================================================
   // RSSI capture, clamped to the reported range
   wire logic [7:0] rssi_clamp = (rx_rssi < lds_pkg::LDS_RSSI_MIN) ? lds_pkg::LDS_RSSI_MIN
      : (rx_rssi > lds_pkg::LDS_RSSI_MAX) ? lds_pkg::LDS_RSSI_MAX : rx_rssi;
   // Margin above sensitivity, monotonic and capped at 95 percent
   wire logic [7:0] margin = (rssi_clamp >= SENSITIVITY) ? 8'h00 : SENSITIVITY - rssi_clamp;
   wire logic [5:0] duty_map = (margin > {2'b00, lds_pkg::LDS_DUTY_MAX})
      ? lds_pkg::LDS_DUTY_MAX : margin[5:0];

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rssi_q <= lds_pkg::LDS_RSSI_RST;
         duty_q <= 6'd0;
      end
      else if (rx_pkt_done)
      begin
         rssi_q <= rssi_clamp;
         duty_q <= duty_map;
      end
   end

   // ==========================================================================
   // PWM step and frame counters
   wire logic step_end = step_cnt_q == 32'(STEP_CYCLES - 1);
   wire logic frame_end = step_end && (step_idx_q == 6'(lds_pkg::LDS_PWM_STEPS - 1));

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         step_cnt_q <= 32'h0000_0000;
         step_idx_q <= 6'd0;
      end
      else
      begin
         step_cnt_q <= step_end ? 32'h0000_0000 : step_cnt_q + 32'h0000_0001;
         if (frame_end)
            step_idx_q <= 6'd0;
         else if (step_end)
            step_idx_q <= step_idx_q + 6'd1;
      end
   end

   // ==========================================================================
   // Hold timer in 100 ms units
   wire logic unit_end = unit_cnt_q == 32'(HOLD_UNIT_CYCLES - 1);
   wire logic hold_forever = hold_q == lds_pkg::LDS_HOLD_FOREVER;
   wire logic hold_expire = unit_end && (hold_cnt_q == 8'h01);

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         unit_cnt_q <= 32'h0000_0000;
         hold_cnt_q <= 8'h00;
         pwm_active_q <= 1'b0;
      end
      else if (rx_pkt_done)
      begin
         unit_cnt_q <= 32'h0000_0000;
         hold_cnt_q <= hold_q;
         pwm_active_q <= (hold_q != lds_pkg::LDS_HOLD_OFF);
      end
      else if (pwm_active_q && !hold_forever)
      begin
         unit_cnt_q <= unit_end ? 32'h0000_0000 : unit_cnt_q + 32'h0000_0001;
         if (unit_end)
            hold_cnt_q <= hold_cnt_q - 8'h01;
         if (hold_expire || (hold_q == lds_pkg::LDS_HOLD_OFF))
            pwm_active_q <= 1'b0;
      end
   end

   // ==========================================================================
   // PWM pin
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         rssi_pwm <= 1'b0;
      else
         rssi_pwm <= pwm_active_q && (step_idx_q < duty_q);
   end
endmodule : lds_link_diag
`default_nettype wire

// file: shared/lds_pkg.sv
// ==========================================================================
// Link diagnostics constants
package lds_pkg;
   // ==========================================================================
   // Command register selectors
   localparam logic [3:0] LDS_SEL_RSSI = 4'h0;
   localparam logic [3:0] LDS_SEL_ACK_FAIL = 4'h1;
   localparam logic [3:0] LDS_SEL_RX_FAULT = 4'h2;
   localparam logic [3:0] LDS_SEL_GOOD = 4'h3;
   localparam logic [3:0] LDS_SEL_CAUSE = 4'h4;
   localparam logic [3:0] LDS_SEL_UNICAST = 4'h5;
   localparam logic [3:0] LDS_SEL_HOLD = 4'h6;
   localparam logic [3:0] LDS_SEL_RETRY = 4'h7;
   localparam logic [3:0] LDS_SEL_CHAN = 4'h8;

   // ==========================================================================
   // Reset values and limits
   localparam logic [7:0] LDS_RSSI_RST = 8'h00;
   localparam logic [15:0] LDS_CNT_RST = 16'h0000;
   localparam logic [15:0] LDS_CNT_MAX = 16'hFFFF;
   localparam logic [7:0] LDS_HOLD_RST = 8'h28;
   localparam logic [7:0] LDS_HOLD_FOREVER = 8'hFF;
   localparam logic [7:0] LDS_HOLD_OFF = 8'h00;
   localparam logic [3:0] LDS_RETRY_RST = 4'hA;
   localparam logic [15:0] LDS_RETRY_MAX = 16'h000F;
   localparam logic [7:0] LDS_RSSI_MIN = 8'h28;
   localparam logic [7:0] LDS_RSSI_MAX = 8'h6E;
   localparam logic [7:0] LDS_SENS_DEF = 8'h6E;
   localparam logic [5:0] LDS_DUTY_MAX = 6'd38;

   // ==========================================================================
   // Reset cause codes
   localparam logic [2:0] LDS_CAUSE_POWER = 3'h0;
   localparam logic [2:0] LDS_CAUSE_WDOG = 3'h2;
   localparam logic [2:0] LDS_CAUSE_SOFT = 3'h3;
   localparam logic [2:0] LDS_CAUSE_LINE = 3'h4;
   localparam logic [2:0] LDS_CAUSE_BROWN = 3'h5;

   // ==========================================================================
   // Timing
   localparam int LDS_CLK_PERIOD_NS = 40;
   localparam int LDS_PWM_PERIOD_US = 8320;
   localparam int LDS_PWM_STEPS = 40;
   localparam int LDS_PWM_STEP_NS = 208000;
   localparam int LDS_HOLD_UNIT_MS = 100;
   localparam int LDS_STEP_CYCLES = LDS_PWM_STEP_NS / LDS_CLK_PERIOD_NS;
   localparam int LDS_HOLD_UNIT_CYCLES = (LDS_HOLD_UNIT_MS * 1000000) / LDS_CLK_PERIOD_NS;

   // ==========================================================================
   // Command sequencer states
   typedef enum logic [0:0]
   {
      LDS_ST_IDLE = 1'b0,
      LDS_ST_CHAN = 1'b1
   } lds_state_t;
endpackage : lds_pkg

// file: bench/lds_chan_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Channel power measurement responder
module lds_chan_model (
   input wire logic clock, // Clock
   input wire logic sys_rst, // Reset
   input wire logic chan_req, // Start pulse
   input wire logic [7:0] chan_index, // Channel
   output logic chan_done, // Done pulse
   output logic [7:0] chan_power // Power, -dBm
);
   logic [3:0] wait_q;
   logic [7:0] pow_q;
   // Odd channels answer slowly, even ones promptly
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wait_q <= 4'h0;
         pow_q <= 8'h00;
      end
      else if (chan_req)
      begin
         wait_q <= chan_index[0] ? 4'h7 : 4'h1;
         pow_q <= 8'h28 + {2'h0, chan_index[5:0]};
      end
      else if (wait_q != 4'h0)
         wait_q <= wait_q - 4'h1;
   end
   // Power valid only with the done pulse, inverted otherwise
   assign chan_done = wait_q == 4'h1;
   assign chan_power = chan_done ? pow_q : ~pow_q;
endmodule : lds_chan_model
`default_nettype wire

// file: bench/lds_link_diag_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Port checker
module lds_link_diag_monitor #(
   parameter int STEP_CYCLES = 4
) (
   input wire logic clock, // Clock
   input wire logic sys_rst, // Reset
   input wire logic cmd_valid, // Strobe
   input wire logic [3:0] cmd_sel, // Selector
   input wire logic cmd_has_param, // Param flag
   input wire logic [15:0] cmd_param, // Param
   input wire logic cmd_ready, // Idle
   input wire logic rsp_valid, // Answer
   input wire logic rsp_error, // Error
   input wire logic [15:0] rsp_data, // Data
   input wire logic rx_pkt_done, // Packet
   input wire logic tx_ack_request, // ACK request
   input wire logic [3:0] mac_retry_limit, // Retries
   input wire logic chan_req, // Measure
   input wire logic [7:0] chan_index, // Channel
   input wire logic chan_done, // Done
   input wire logic [7:0] chan_power, // Power
   input wire logic rssi_pwm // PWM pin
);
   logic seen_q;
   logic [15:0] hi_q;
   wire logic tk = cmd_valid && cmd_ready;
   // Packet seen flag and length of the current high run
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         seen_q <= 1'h0;
         hi_q <= 16'h0000;
      end
      else
      begin
         seen_q <= seen_q | rx_pkt_done;
         hi_q <= rssi_pwm ? hi_q + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   rssi_zero_a: assert property (
      tk && cmd_sel == 4'h0 && !cmd_has_param && !seen_q
      |=> rsp_valid && !rsp_error && rsp_data == 16'h0000) else $error("rssi not zero");
   ro_write_a: assert property (
      tk && cmd_sel == 4'h0 && cmd_has_param |=> rsp_valid && rsp_error)
      else $error("rssi write accepted");
   chan_take_a: assert property (
      tk && cmd_sel == 4'h8 && cmd_has_param && cmd_param[15:8] == 8'h00
      |=> chan_req && !cmd_ready && {8'h00, chan_index} == $past(cmd_param))
      else $error("channel query not started");
   chan_miss_a: assert property (
      tk && cmd_sel == 4'h8 && !cmd_has_param |=> rsp_valid && rsp_error && !chan_req)
      else $error("channel query without channel accepted");
   chan_ans_a: assert property (
      chan_done && !cmd_ready
      |=> rsp_valid && !rsp_error && rsp_data == {8'h00, $past(chan_power)})
      else $error("channel power answer wrong");
   retry_set_a: assert property (
      tk && cmd_sel == 4'h7 && cmd_has_param && cmd_param <= 16'h000F
      |=> ##1 {12'h000, mac_retry_limit} == $past(cmd_param, 2))
      else $error("retry limit not set");
   retry_err_a: assert property (
      tk && cmd_sel == 4'h7 && cmd_has_param && cmd_param > 16'h000F
      |=> rsp_error ##1 $stable(mac_retry_limit)) else $error("bad retry limit taken");
   ack_req_a: assert property (
      tx_ack_request == (mac_retry_limit != 4'h0)) else $error("ack request mismatch");
   pwm_idle_a: assert property (
      !seen_q |-> !rssi_pwm) else $error("pwm active before packet");
   duty_cap_a: assert property (
      hi_q <= 38 * STEP_CYCLES) else $error("pwm duty above limit");
   chan_c: cover property (chan_req);
   pwm_c: cover property ($rose(rssi_pwm));
   err_c: cover property (rsp_valid && rsp_error);
endmodule : lds_link_diag_monitor
bind lds_link_diag lds_link_diag_monitor #(.STEP_CYCLES(STEP_CYCLES)) i_mon (
   .clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_sel(cmd_sel),
   .cmd_has_param(cmd_has_param), .cmd_param(cmd_param), .cmd_ready(cmd_ready),
   .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_data(rsp_data),
   .rx_pkt_done(rx_pkt_done), .tx_ack_request(tx_ack_request),
   .mac_retry_limit(mac_retry_limit), .chan_req(chan_req), .chan_index(chan_index),
   .chan_done(chan_done), .chan_power(chan_power), .rssi_pwm(rssi_pwm));
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Testbench
module tb;
   typedef struct packed {logic [3:0] s; logic h; logic [15:0] p; logic e; logic [15:0] d;} lds_row_t;
   logic clock, sys_rst, cmd_valid, cmd_has_param, mack, cmd_ready, rsp_valid, rsp_error;
   logic tx_ack_request, chan_req, chan_done, rssi_pwm;
   logic [2:0] reset_cause;
   logic [3:0] cmd_sel, mac_retry_limit;
   logic [4:0] ev;
   logic [7:0] rx_rssi, chan_index, chan_power;
   logic [15:0] cmd_param, rsp_data;
   int bad_count = 0;
   int n_compared = 0;
   lds_row_t rows [15] = '{'{4'h0, 1'h0, 16'h0000, 1'h0, 16'h0000},
      '{4'h3, 1'h0, 16'h0000, 1'h0, 16'h0000}, '{4'h6, 1'h0, 16'h0000, 1'h0, 16'h0028},
      '{4'h7, 1'h0, 16'h0000, 1'h0, 16'h000A}, '{4'h1, 1'h1, 16'hFFFE, 1'h0, 16'h0000},
      '{4'h2, 1'h1, 16'hFFFE, 1'h0, 16'h0000}, '{4'h3, 1'h1, 16'h1234, 1'h0, 16'h0000},
      '{4'h0, 1'h1, 16'h0050, 1'h1, 16'h0000}, '{4'h5, 1'h1, 16'h0001, 1'h1, 16'h0000},
      '{4'h9, 1'h0, 16'h0000, 1'h1, 16'h0000}, '{4'h8, 1'h0, 16'h0000, 1'h1, 16'h0000},
      '{4'h8, 1'h1, 16'h0100, 1'h1, 16'h0000}, '{4'h8, 1'h1, 16'h0031, 1'h0, 16'h0059},
      '{4'h8, 1'h1, 16'h0000, 1'h0, 16'h0028}, '{4'h1, 1'h0, 16'h0000, 1'h0, 16'hFFFE}};
   logic [2:0] causes [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
   logic [15:0] codes [6] = '{16'h0000, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0000};
   lds_link_diag #(.STEP_CYCLES(4), .HOLD_UNIT_CYCLES(10)) i_dut (.clock(clock),
      .sys_rst(sys_rst), .reset_cause(reset_cause), .cmd_valid(cmd_valid), .cmd_sel(cmd_sel),
      .cmd_has_param(cmd_has_param), .cmd_param(cmd_param), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_data(rsp_data), .rx_pkt_done(ev[4]),
      .rx_rssi(rx_rssi), .rx_integrity_err(ev[3]), .rx_good_frame(ev[2]), .rx_is_mac_ack(mack),
      .tx_unicast(ev[1]), .ack_timeout(ev[0]), .tx_ack_request(tx_ack_request),
      .mac_retry_limit(mac_retry_limit), .chan_req(chan_req), .chan_index(chan_index),
      .chan_done(chan_done), .chan_power(chan_power), .rssi_pwm(rssi_pwm));
   lds_chan_model i_chan (.clock(clock), .sys_rst(sys_rst), .chan_req(chan_req),
      .chan_index(chan_index), .chan_done(chan_done), .chan_power(chan_power));
   // Clock
   initial
   begin
      clock = 1'h0;
      forever #20 clock = ~clock;
   end
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cmd(input lds_row_t r);
      int k;
      @(posedge clock);
      cmd_valid <= 1'h1;
      {cmd_sel, cmd_has_param, cmd_param} <= {r.s, r.h, r.p};
      @(posedge clock);
      cmd_valid <= 1'h0;
      k = 0;
      #1;
      while (rsp_valid !== 1'h1 && k < 20)
      begin
         @(posedge clock);
         #1;
         k++;
      end
      if (rsp_valid !== 1'h1)
      begin
         bad_count++;
         wrap_up();
      end
      else
      begin
         chk("rsp_error", {15'h0000, rsp_error}, {15'h0000, r.e});
         chk("rsp_data", rsp_data, r.d);
      end
   endtask : cmd
   task automatic pulse(input logic [4:0] b, input logic [7:0] r);
      @(posedge clock);
      ev <= b;
      rx_rssi <= r;
      @(posedge clock);
      ev <= 5'h00;
   endtask : pulse
   task automatic meas(input logic [15:0] d);
      logic [15:0] n;
      n = 16'h0000;
      repeat (160)
      begin
         @(posedge clock);
         #1;
         n = n + {15'h0000, rssi_pwm};
      end
      chk("pwm_high", n, d);
   endtask : meas
   task automatic rst(input logic [2:0] c);
      @(posedge clock);
      sys_rst <= 1'h1;
      reset_cause <= c;
      repeat (16) @(posedge clock);
      sys_rst <= 1'h0;
   endtask : rst
   // Main sequence
   initial
   begin
      {sys_rst, cmd_valid, cmd_has_param, mack, ev, rx_rssi} = {1'h1, 16'h0000};
      {reset_cause, cmd_sel, cmd_param} = {3'h4, 4'h0, 16'h0000};
      rst(3'h4);
      foreach (rows[i]) cmd(rows[i]);
      pulse(5'h01, 8'h00);
      pulse(5'h01, 8'h00);
      cmd('{4'h1, 1'h0, 16'h0000, 1'h0, 16'hFFFF});
      pulse(5'h08, 8'h00);
      cmd('{4'h2, 1'h0, 16'h0000, 1'h0, 16'hFFFF});
      @(posedge clock);
      mack <= 1'h1;
      pulse(5'h04, 8'h00);
      mack <= 1'h0;
      pulse(5'h04, 8'h00);
      cmd('{4'h3, 1'h0, 16'h0000, 1'h0, 16'h1235});
      pulse(5'h02, 8'h00);
      cmd('{4'h7, 1'h1, 16'h0000, 1'h0, 16'h0000});
      @(posedge clock);
      #1;
      chk("tx_ack_request", {15'h0000, tx_ack_request}, 16'h0000);
      pulse(5'h02, 8'h00);
      cmd('{4'h5, 1'h0, 16'h0000, 1'h0, 16'h0001});
      cmd('{4'h7, 1'h1, 16'h0010, 1'h1, 16'h0000});
      cmd('{4'h7, 1'h0, 16'h0000, 1'h0, 16'h0000});
      pulse(5'h10, 8'h60);
      repeat (4) @(posedge clock);
      meas(16'h0038);
      cmd('{4'h0, 1'h0, 16'h0000, 1'h0, 16'h0060});
      repeat (400) @(posedge clock);
      meas(16'h0000);
      cmd('{4'h6, 1'h1, 16'h00FF, 1'h0, 16'h0000});
      pulse(5'h10, 8'h20);
      repeat (600) @(posedge clock);
      meas(16'h0098);
      cmd('{4'h0, 1'h0, 16'h0000, 1'h0, 16'h0028});
      pulse(5'h10, 8'h70);
      repeat (4) @(posedge clock);
      meas(16'h0000);
      cmd('{4'h0, 1'h0, 16'h0000, 1'h0, 16'h006E});
      for (int i = 0; i < 6; i++)
      begin
         rst(causes[i]);
         cmd('{4'h4, 1'h0, 16'h0000, 1'h0, codes[i]});
         cmd('{4'h2, 1'h0, 16'h0000, 1'h0, 16'h0000});
      end
      wrap_up();
   end
endmodule : tb
`default_nettype wire
